// [hdl/pmw_ctrl.sv]
// power mode and wake controller: battery monitor, wake sources,
// host acknowledge window, usb limit, power path and config store
// assumes synchronous pins and a battery voltage word in mV
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - battery below low level longer than 5 ms forces power-off unless the adapter is present
// - low level is 2.5 V plus 50 mV per code, up to 3.5 V
// - low condition ends only 50 mV above the low level
// - warning event fires 200 mV above the low level
// - adapter detection starts power-up whatever the battery voltage
// - adapter and usb detection are deglitched for 32 ms
// - usb with battery above alarm level starts power-up
// - usb with low battery waits until battery recovers, then powers up
// - four low event bits record battery, button, adapter, usb wake
// - wake bits clear whenever the device powers off
// - usb suspend pin high disables the usb current path
// - usb current limit defaults to 100 mA
// - charge current on the usb route never exceeds the selected usb limit
// - 800 mA limit is reachable only through the register
// - power path switches follow adapter, usb or battery route
// - fourteen config registers load defaults on every reset
// - standby wakes only on button, adapter or usb
// - system reset output held low unless active
module pmw_ctrl
#(
    parameter int         BAT_LOW_CYC_P = pmw_pkg::BAT_LOW_CYC,
    parameter int         DEGLITCH_P    = pmw_pkg::DEGLITCH_CYC,
    parameter int         ACK_WIN_P     = pmw_pkg::ACK_WIN_CYC,
    parameter logic [7:0] BAT_LOW_DEF_P = pmw_pkg::BAT_LOW_DEF
)
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            reset_n,
    // pins and measurements
    input  wire pmw_pkg::pmw_pins_t pins,
    input  wire logic [11:0]     batteryMv,
    input  wire logic [10:0]     chgProgMa,
    // configuration access
    input  wire pmw_pkg::pmw_cfgwr_t cfgWr,
    input  wire logic [3:0]      cfgRdAddr,
    output logic [7:0]           cfgRdData,
    // status and events
    output pmw_pkg::pmw_mode_t   modeOut,
    output logic [3:0]           wakeSrc,
    output logic                 seqStart,
    output logic                 batWarnPulse,
    // power path
    output pmw_pkg::pmw_path_t   pathOut,
    // open-drain system reset
    output logic                 sysResetOut,
    output logic                 sysResetOe
);
    import pmw_pkg::*;

    localparam int LOW_W = $clog2(BAT_LOW_CYC_P + 1);
    localparam int ACK_W = $clog2(ACK_WIN_P + 1);
    localparam logic [CFG_NUM*8-1:0] CFG_RST =
        (CFG_NUM*8)'(BAT_LOW_DEF_P) << (8 * CFG_BATLOW);

    typedef struct packed {
        pmw_mode_t                 mode;
        logic [CFG_NUM-1:0][7:0]   cfg;
        logic                      batLow;
        logic                      batWarn;
        logic [LOW_W-1:0]          lowCnt;
        logic [ACK_W-1:0]          ackCnt;
        logic                      usbPend;
        logic                      seqStart;
        logic                      warnPulse;
        logic [7:0]                rdData;
        pmw_path_t                 path;
        logic                      rstLvl;
        logic                      rstOe;
    } pmw_core_t;

    pmw_core_t r;
    pmw_core_t n;
    logic [2:0] dgl;
    logic [2:0] rise;
    logic [2:0] rawIn;

    assign rawIn = {pins.usbPower, pins.adapter, pins.pushButton};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_dg
            pmw_deglitch #(.CYC(DEGLITCH_P)) u_dg
            (
                .clk     (clk),
                .reset_n (reset_n),
                .rawIn   (rawIn[gi]),
                .level   (dgl[gi]),
                .rise    (rise[gi])
            );
        end
    endgenerate

    logic [4:0]  thrCode;
    logic [11:0] lowMv;
    logic [11:0] warnMv;
    logic        shutdown;
    logic        ack;
    logic        batRecover;
    logic        usbWake;
    logic [3:0]  wakeBits;
    logic [1:0]  regLim;
    logic [1:0]  limCode;
    logic [10:0] limMa;

    always_comb
    begin
        n = r;
        n.seqStart  = 1'b0;
        n.warnPulse = 1'b0;
        wakeBits    = 4'h0;

        // codes above the range clamp to the top threshold
        thrCode = (r.cfg[CFG_BATLOW][4:0] > BAT_CODE_MAX) ?
                  BAT_CODE_MAX : r.cfg[CFG_BATLOW][4:0];
        lowMv  = BAT_LOW_BASE_MV + 12'(thrCode) * BAT_LOW_STEP_MV;
        warnMv = lowMv + BAT_WARN_MV;

        if (batteryMv < lowMv)
            n.batLow = 1'b1;
        else if (batteryMv > lowMv + BAT_HYST_MV)
            n.batLow = 1'b0;

        if (batteryMv < warnMv)
        begin
            n.batWarn = 1'b1;
            n.warnPulse = !r.batWarn;
        end
        else if (batteryMv > warnMv + BAT_HYST_MV)
            n.batWarn = 1'b0;

        if (!r.batLow)
            n.lowCnt = '0;
        else if (r.lowCnt != LOW_W'(BAT_LOW_CYC_P))
            n.lowCnt = r.lowCnt + 1'b1;

        // external adapter keeps the system up on a flat battery
        // a battery recovering this cycle must not mask its own wake
        shutdown = (r.lowCnt == LOW_W'(BAT_LOW_CYC_P)) && n.batLow
                   && !dgl[DG_ADP];
        ack = r.cfg[CFG_PON][PON_ACK] | pins.power_ack_pin;
        batRecover = r.batLow && !n.batLow;

        // usb seen on a low battery waits for the charge to recover
        if (rise[DG_USB] && r.batLow)
            n.usbPend = 1'b1;
        if (!dgl[DG_USB])
            n.usbPend = 1'b0;
        usbWake = dgl[DG_USB] && !r.batLow
                  && (rise[DG_USB] || r.usbPend);

        wakeBits[PON_ADP] = rise[DG_ADP];
        wakeBits[PON_USB] = usbWake;
        wakeBits[PON_BTN] = rise[DG_BTN] && (r.mode == PMW_STBY);
        wakeBits[PON_BAT] = batRecover && (r.mode == PMW_OFF);

        unique case (r.mode)
            PMW_OFF, PMW_STBY:
            begin
                if (shutdown)
                    n.mode = PMW_OFF;
                else if (wakeBits != 4'h0)
                begin
                    n.mode   = PMW_WAIT;
                    n.ackCnt = '0;
                    n.seqStart = 1'b1;
                    n.usbPend  = 1'b0;
                    n.cfg[CFG_PON][3:0] = wakeBits;
                    n.cfg[CFG_PON][PON_ACK] = 1'b0;
                end
            end
            PMW_WAIT:
            begin
                n.ackCnt = r.ackCnt + 1'b1;
                if (shutdown)
                    n.mode = PMW_OFF;
                else if (ack)
                    n.mode = PMW_ACT;
                else if (r.ackCnt == ACK_W'(ACK_WIN_P - 1))
                    n.mode = PMW_STBY;
            end
            PMW_ACT:
            begin
                if (shutdown)
                    n.mode = PMW_OFF;
            end
        endcase

        if (n.mode == PMW_OFF)
            n.cfg[CFG_PON][3:0] = 4'h0;

        // host write lands last so a set beats the hardware clear
        if (cfgWr.en && (cfgWr.addr < 4'(CFG_NUM)))
        begin
            if (cfgWr.addr == CFG_PON)
                n.cfg[CFG_PON][7:4] = cfgWr.data[7:4];
            else
                n.cfg[cfgWr.addr] = cfgWr.data;
        end

        n.rdData = (cfgRdAddr < 4'(CFG_NUM)) ? r.cfg[cfgRdAddr] : 8'h00;

        // register code 500 or 800 overrides the pin
        regLim = r.cfg[CFG_LIMIT][1:0];
        if (regLim == LIM_500 || regLim == LIM_800)
            limCode = regLim;
        else
            limCode = pins.usbLimitSel ? LIM_500 : LIM_100;
        unique case (limCode)
            LIM_500: limMa = LIM_500_MA;
            LIM_800: limMa = LIM_800_MA;
            default: limMa = LIM_100_MA;
        endcase

        n.path.usbLimit = limCode;
        if (dgl[DG_ADP])
        begin
            n.path.usbSwitch = 1'b0;
            n.path.batSwitch = BSW_REG;
            n.path.chgCurMa  = chgProgMa;
        end
        else if (dgl[DG_USB] && !pins.usbSuspend)
        begin
            n.path.usbSwitch = 1'b1;
            n.path.batSwitch = BSW_REG;
            n.path.chgCurMa  = (chgProgMa > limMa) ? limMa : chgProgMa;
        end
        else
        begin
            n.path.usbSwitch = 1'b0;
            n.path.batSwitch = BSW_FULL;
            n.path.chgCurMa  = 11'h000;
        end

        n.rstLvl = 1'b0;
        n.rstOe  = (n.mode != PMW_ACT);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // every reset reloads the config defaults
            r <= '{mode: PMW_OFF, cfg: CFG_RST, batLow: 1'b1,
                   batWarn: 1'b1, path: '{1'b0, BSW_FULL, LIM_100, 11'h000},
                   rstOe: 1'b1, default: '0};
        end
        else
            r <= n;
    end

    assign modeOut      = r.mode;
    assign wakeSrc      = r.cfg[CFG_PON][3:0];
    assign seqStart     = r.seqStart;
    assign batWarnPulse = r.warnPulse;
    assign cfgRdData    = r.rdData;
    assign pathOut      = r.path;
    assign sysResetOut  = r.rstLvl;
    assign sysResetOe   = r.rstOe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_shutdown;
        shutdown |=> r.mode == PMW_OFF;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("filtered battery low did not power off");

    property p_wakeClr;
        r.mode == PMW_OFF |-> r.cfg[CFG_PON][3:0] == 4'h0;
    endproperty
    a_wakeClr: assert property (p_wakeClr)
        else $error("wake bits set while powered off");

    property p_ackTimeout;
        (r.mode == PMW_WAIT && r.ackCnt == ACK_W'(ACK_WIN_P - 1)
         && !ack && !shutdown) |=> r.mode == PMW_STBY;
    endproperty
    a_ackTimeout: assert property (p_ackTimeout)
        else $error("missing acknowledge did not return to standby");

    sequence s_start;
        r.mode == PMW_STBY ##1 r.mode == PMW_WAIT;
    endsequence
    property p_start;
        s_start |-> r.seqStart && r.ackCnt == '0 && wakeSrc != 4'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("power-up began without sequencer start or source");

    property p_adpWake;
        (r.mode == PMW_STBY && rise[DG_ADP] && !shutdown)
        |=> r.mode == PMW_WAIT && wakeSrc[PON_ADP];
    endproperty
    a_adpWake: assert property (p_adpWake)
        else $error("adapter detection did not start power-up");

    property p_usbLow;
        ((r.mode == PMW_OFF || r.mode == PMW_STBY) && r.batLow && n.batLow
         && rise[DG_USB] && !rise[DG_ADP] && !rise[DG_BTN])
        |=> r.mode != PMW_WAIT && r.usbPend;
    endproperty
    a_usbLow: assert property (p_usbLow)
        else $error("usb woke the device on a low battery");

    property p_susp;
        pins.usbSuspend |=> !pathOut.usbSwitch;
    endproperty
    a_susp: assert property (p_susp)
        else $error("usb path on during suspend");

    property p_cap;
        pathOut.usbSwitch && pathOut.usbLimit == LIM_100
        |-> pathOut.chgCurMa <= LIM_100_MA;
    endproperty
    a_cap: assert property (p_cap)
        else $error("charge current above usb limit");

    property p_battOnly;
        !dgl[DG_ADP] && !dgl[DG_USB]
        |=> pathOut.batSwitch == BSW_FULL && !pathOut.usbSwitch;
    endproperty
    a_battOnly: assert property (p_battOnly)
        else $error("battery route switches wrong");

    property p_rst;
        r.mode != PMW_ACT ##1 r.mode != PMW_ACT |-> sysResetOe;
    endproperty
    a_rst: assert property (p_rst)
        else $error("system reset released outside active mode");

endmodule
`default_nettype wire

// [common/pmw_pkg.sv]
// constants and carrier types for the power mode and wake controller
// assumes a 50 MHz core clock from the internal oscillator
package pmw_pkg;

    // timing
    localparam int CLK_KHZ      = 50000;
    localparam int BAT_LOW_MS   = 5;
    localparam int DEGLITCH_MS  = 32;
    localparam int ACK_WIN_MS   = 128;
    localparam int BAT_LOW_CYC  = BAT_LOW_MS * CLK_KHZ;
    localparam int DEGLITCH_CYC = DEGLITCH_MS * CLK_KHZ;
    localparam int ACK_WIN_CYC  = ACK_WIN_MS * CLK_KHZ;

    // battery thresholds in mV
    localparam logic [11:0] BAT_LOW_BASE_MV = 12'h9C4;
    localparam logic [11:0] BAT_LOW_STEP_MV = 12'h032;
    localparam logic [11:0] BAT_HYST_MV     = 12'h032;
    localparam logic [11:0] BAT_WARN_MV     = 12'h0C8;
    localparam logic [4:0]  BAT_CODE_MAX    = 5'h14;
    localparam logic [7:0]  BAT_LOW_DEF     = 8'h0A;

    // configuration register file
    localparam int          CFG_NUM    = 14;
    localparam logic [3:0]  CFG_PON    = 4'h0;
    localparam logic [3:0]  CFG_LIMIT  = 4'h1;
    localparam logic [3:0]  CFG_BATLOW = 4'h2;
    localparam int          PON_BAT    = 0;
    localparam int          PON_BTN    = 1;
    localparam int          PON_ADP    = 2;
    localparam int          PON_USB    = 3;
    localparam int          PON_ACK    = 4;

    // usb current limit codes and values
    localparam logic [1:0]  LIM_100    = 2'h0;
    localparam logic [1:0]  LIM_500    = 2'h1;
    localparam logic [1:0]  LIM_800    = 2'h2;
    localparam logic [10:0] LIM_100_MA = 11'h064;
    localparam logic [10:0] LIM_500_MA = 11'h1F4;
    localparam logic [10:0] LIM_800_MA = 11'h320;

    // deglitched input lanes
    localparam int DG_BTN = 0;
    localparam int DG_ADP = 1;
    localparam int DG_USB = 2;

    typedef enum logic [3:0] {
        PMW_OFF  = 4'b0001,
        PMW_STBY = 4'b0010,
        PMW_WAIT = 4'b0100,
        PMW_ACT  = 4'b1000
    } pmw_mode_t;

    typedef enum logic [1:0] {
        BSW_REG  = 2'h1,
        BSW_FULL = 2'h2
    } pmw_bsw_t;

    typedef struct packed {
        logic pushButton;
        logic adapter;
        logic usbPower;
        logic usbSuspend;
        logic usbLimitSel;
        logic power_ack_pin;
    } pmw_pins_t;

    typedef struct packed {
        logic       en;
        logic [3:0] addr;
        logic [7:0] data;
    } pmw_cfgwr_t;

    typedef struct packed {
        logic        usbSwitch;
        pmw_bsw_t    batSwitch;
        logic [1:0]  usbLimit;
        logic [10:0] chgCurMa;
    } pmw_path_t;

endpackage

// [hdl/pmw_deglitch.sv]
// input deglitch filter: level follows input only after it held steady
// assumes the input is already synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pmw_deglitch
#(
    parameter int CYC = 1600000
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // raw and filtered level
    input  wire logic rawIn,
    output logic      level,
    output logic      rise
);
    import pmw_pkg::*;

    localparam int W = $clog2(CYC + 1);

    typedef struct packed {
        logic         level;
        logic         rise;
        logic [W-1:0] cnt;
    } pmw_dg_t;

    pmw_dg_t r;
    pmw_dg_t n;

    always_comb
    begin
        n = r;
        n.rise = 1'b0;
        if (rawIn == r.level)
            n.cnt = '0;
        else if (r.cnt == W'(CYC - 1))
        begin
            n.level = rawIn;
            n.rise  = rawIn;
            n.cnt   = '0;
        end
        else
            n.cnt = r.cnt + 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            r <= '0;
        else
            r <= n;
    end

    assign level = r.level;
    assign rise  = r.rise;

    property p_dgHold;
        @(posedge clk) disable iff (!reset_n)
        $changed(r.level) |-> $past(r.cnt) == W'(CYC - 1);
    endproperty
    a_dgHold: assert property (p_dgHold)
        else $error("deglitched level changed before hold time");

endmodule
`default_nettype wire

// [bench/pmw_host_model.sv]
// host processor stand-in: raises the ack pin after a set delay
// assumes seqStart is a one-cycle pulse from the controller
`timescale 1ns/1ns
`default_nettype none
module pmw_host_model
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // controller status
    input  wire logic               seqStart,
    input  wire pmw_pkg::pmw_mode_t modeOut,
    // bench control
    input  wire logic               ackOn,
    input  wire logic [7:0]         ackDelay,
    // acknowledge pin
    output logic                    power_ack_pin
);
    import pmw_pkg::*;
    logic [7:0] cnt_reg;
    logic       armed_reg;
    // a slow host is modelled by a long delay; off means no answer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_reg   <= 8'h00;
            armed_reg <= 1'b0;
            power_ack_pin  <= 1'b0;
        end
        else if (seqStart)
        begin
            cnt_reg   <= ackDelay;
            armed_reg <= ackOn;
            power_ack_pin  <= 1'b0;
        end
        else if (armed_reg && cnt_reg == 8'h00)
        begin
            armed_reg <= 1'b0;
            power_ack_pin  <= 1'b1;
        end
        else if (armed_reg)
            cnt_reg <= cnt_reg - 8'h01;
        else if (modeOut == PMW_OFF || modeOut == PMW_STBY)
            power_ack_pin <= 1'b0;
    end
endmodule
`default_nettype wire

// [bench/tb_pmw_ctrl.sv]
// self-checking bench for the power mode and wake controller
// assumes short timing parameters and the host model on the ack pin
`timescale 1ns/1ns
`default_nettype none
module tb_pmw_ctrl;
    import pmw_pkg::*;
    localparam int DG   = 4;
    localparam int WIN  = 20;
    localparam int LOW  = 8;
    localparam int CEIL = 2000;

    logic        clk;
    logic        reset_n;
    pmw_pins_t   pinsTb;
    pmw_pins_t   pinsDut;
    logic [11:0] batteryMv;
    logic [10:0] chgProgMa;
    pmw_cfgwr_t  cfgWr;
    logic [3:0]  cfgRdAddr;
    logic [7:0]  cfgRdData;
    pmw_mode_t   modeOut;
    logic [3:0]  wakeSrc;
    logic        seqStart;
    logic        batWarnPulse;
    pmw_path_t   pathOut;
    logic        sysResetOut;
    logic        sysResetOe;
    logic        hostAck;
    logic        ackOn;
    logic [7:0]  ackDelay;
    logic [7:0]  rd;
    int          miscompares;
    int          samplesChecked;
    int          cycles;
    int          i;
    int          srcBit [3]  = '{PON_ADP, PON_USB, PON_BTN};
    logic [1:0]  limCode [4] = '{LIM_100, LIM_100, LIM_500, LIM_800};
    logic        limPin [4]  = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [1:0]  limExp [4]  = '{LIM_100, LIM_500, LIM_500, LIM_800};
    logic [10:0] limMa [4]   = '{LIM_100_MA, LIM_500_MA, LIM_500_MA,
                                 LIM_800_MA};

    // ack lane belongs to the host model
    always_comb
    begin
        pinsDut          = pinsTb;
        pinsDut.power_ack_pin = hostAck;
    end

    pmw_ctrl #(.BAT_LOW_CYC_P(LOW), .DEGLITCH_P(DG), .ACK_WIN_P(WIN),
               .BAT_LOW_DEF_P(BAT_LOW_DEF)) i_dut (
        .clk, .reset_n, .pins(pinsDut), .batteryMv, .chgProgMa, .cfgWr,
        .cfgRdAddr, .cfgRdData, .modeOut, .wakeSrc, .seqStart,
        .batWarnPulse, .pathOut, .sysResetOut, .sysResetOe);

    pmw_host_model i_host (
        .clk, .reset_n, .seqStart, .modeOut, .ackOn, .ackDelay,
        .power_ack_pin(hostAck));

    always #10 clk = ~clk;

    // hang guard: the whole run needs well under the ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == CEIL)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
    begin
        $display("checks %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
    begin
        samplesChecked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    end
    endtask

    task automatic cyc(input int n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask

    task automatic cfgWrite(input logic [3:0] a, input logic [7:0] d);
    begin
        @(posedge clk);
        cfgWr <= '{en: 1'b1, addr: a, data: d};
        @(posedge clk);
        cfgWr.en <= 1'b0;
    end
    endtask

    task automatic cfgRead(input logic [3:0] a);
    begin
        @(posedge clk);
        cfgRdAddr <= a;
        cyc(1);
        rd = cfgRdData;
    end
    endtask

    // bounded wait for a one-cycle event pulse
    task automatic waitSig(input bit warn, input int maxCyc);
        logic got;
    begin
        got = 1'b0;
        for (int k = 0; k < maxCyc && !got; k++)
        begin
            cyc(1);
            got = warn ? batWarnPulse : seqStart;
        end
        check(got, 1'b1, "event pulse");
    end
    endtask

    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        pinsTb = '0;
        batteryMv = 12'hCE4;
        chgProgMa = 11'h384;
        cfgWr = '0;
        cfgRdAddr = 4'h0;
        ackOn = 1'b0;
        ackDelay = 8'h05;
        miscompares = 0;
        samplesChecked = 0;
        cycles = 0;
        cyc(3);
        check(modeOut, PMW_OFF, "reset mode");
        check(sysResetOut, 1'b0, "reset level");
        check(pathOut, {1'b0, BSW_FULL, LIM_100, 11'h000}, "path");
        check(sysResetOe, 1'b1, "reset pull");
        @(negedge clk);
        reset_n = 1'b1;
        waitSig(1'b0, 6);
        check(modeOut, PMW_WAIT, "mode");
        check(wakeSrc, 4'h1, "wake bits");
        cfgRead(CFG_BATLOW);
        check(rd, BAT_LOW_DEF, "low code");
        cfgRead(CFG_LIMIT);
        check(rd, 8'h00, "limit code");
        cfgRead(4'hE);
        check(rd, 8'h00, "unmapped");
        cyc(WIN - 9);
        check(modeOut, PMW_WAIT, "still waiting");
        cyc(6);
        check(modeOut, PMW_STBY, "no ack");
        check(sysResetOe, 1'b1, "standby pull");
        // short button glitch must not wake
        @(posedge clk);
        pinsTb.pushButton <= 1'b1;
        repeat (DG - 1) @(posedge clk);
        pinsTb.pushButton <= 1'b0;
        cyc(10);
        check(modeOut, PMW_STBY, "glitch");
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk);
            pinsTb.adapter    <= (i == 0);
            pinsTb.usbPower   <= (i == 1);
            pinsTb.pushButton <= (i == 2);
            waitSig(1'b0, DG + 4);
            check(modeOut, PMW_WAIT, "wake mode");
            check(wakeSrc[srcBit[i]], 1'b1, "source bit");
            @(posedge clk);
            pinsTb <= '0;
            if (i < 2)
            begin
                cyc(WIN + 3);
                check(modeOut, PMW_STBY, "timeout");
            end
        end
        cfgWrite(CFG_PON, 8'h10);
        cyc(3);
        check(modeOut, PMW_ACT, "reg ack");
        check(sysResetOe, 1'b0, "active release");
        cfgRead(CFG_PON);
        check(rd[PON_ACK], 1'b1, "ack bit");
        @(posedge clk);
        pinsTb.adapter <= 1'b1;
        cyc(DG + 3);
        check(pathOut.usbSwitch, 1'b0, "adp usb sw");
        check(pathOut.batSwitch, BSW_REG, "adp bat sw");
        check(pathOut.chgCurMa, 11'h384, "adp cur");
        @(posedge clk);
        pinsTb.adapter  <= 1'b0;
        pinsTb.usbPower <= 1'b1;
        cyc(DG + 3);
        for (i = 0; i < 4; i++)
        begin
            cfgWrite(CFG_LIMIT, {6'h00, limCode[i]});
            pinsTb.usbLimitSel <= limPin[i];
            cyc(3);
            check(pathOut.usbSwitch, 1'b1, "usb sw");
            check(pathOut.usbLimit, limExp[i], "limit");
            check(pathOut.chgCurMa, limMa[i], "capped");
        end
        @(posedge clk);
        pinsTb.usbSuspend <= 1'b1;
        cyc(3);
        check(pathOut, {1'b0, BSW_FULL, LIM_800, 11'h000},
              "suspend");
        @(posedge clk);
        pinsTb <= '0;
        batteryMv <= 12'hC1C;
        waitSig(1'b1, 4);
        @(posedge clk);
        batteryMv <= 12'hBC2;
        cyc(LOW + 4);
        check(modeOut, PMW_ACT, "above low");
        cfgWrite(CFG_BATLOW, 8'h0C);
        cyc(LOW - 2);
        check(modeOut, PMW_ACT, "low too short");
        cyc(6);
        check(modeOut, PMW_OFF, "low off");
        check(wakeSrc, 4'h0, "bits cleared");
        check(sysResetOe, 1'b1, "off pull");
        @(posedge clk);
        batteryMv <= 12'hC30;
        cyc(LOW + 4);
        check(modeOut, PMW_OFF, "hysteresis");
        @(posedge clk);
        batteryMv <= 12'hC58;
        ackOn <= 1'b1;
        waitSig(1'b0, 6);
        check(wakeSrc, 4'h1, "insert bit");
        cyc(10);
        check(modeOut, PMW_ACT, "pin ack");
        // usb on a flat battery must wait for the charge
        @(posedge clk);
        batteryMv <= 12'hBEA;
        cyc(LOW + 4);
        check(modeOut, PMW_OFF, "low again");
        @(posedge clk);
        pinsTb.usbPower <= 1'b1;
        cyc(DG + 4);
        check(modeOut, PMW_OFF, "usb on low battery");
        @(posedge clk);
        batteryMv <= 12'hC58;
        waitSig(1'b0, 6);
        check(modeOut, PMW_WAIT, "usb after recovery");
        conclude();
    end
endmodule
`default_nettype wire
